//--- gpio_input_function_dispatch.sv
// Notes on behaviour
// - four-bit mask, one bit per channel
// - global functions device-wide, others masked channels
// - code 0010 falling edge starts fault dump
// - code 0011 low powers down current outputs
// - code 0100 low powers down voltage outputs
// - code 0101 falling edge starts safe shutdown
// - code 0111 low applies global clear
// - code 1000 falling edge loads synced channels
// - code 1001 fall stops, rise starts waveform
// - code 1010 fall margin low, rise high
// - code 1011 fall enters reset, rise leaves
// - reset clears code unless kept in NVM
// - code 1100 fall permits NVM, high blocks
// - code 1101 high rejects writes except unlock
// - pin acts only when input enable set
// - reference select picks reference or mode pin
// - two-bit action chooses shutdown sequence
// - shutdown done flag, cleared on read
// - filter enable adds glitch filter delay
module gpio_input_function_dispatch
  import gpio_input_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pin
  input wire logic gpio_pin,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic unlock_write,
  // companion settings
  input wire logic [3:0] channel_sync_select,
  input wire logic nvm_keeps_reset_cfg,
  input wire logic slew_done,
  // global actions
  output logic fault_dump_start,
  output logic output_clear,
  output logic device_reset,
  output logic nvm_write_allowed,
  output logic map_locked,
  output logic reference_pin_select,
  // channel actions
  output logic [3:0] current_output_down,
  output logic [3:0] voltage_output_down,
  output logic [3:0] sync_output_load,
  output logic [3:0] wave_stop,
  output logic [3:0] wave_start,
  output logic [3:0] margin_low,
  output logic [3:0] margin_high,
  // safe shutdown
  output logic protect_load_nvm,
  output logic protect_slew_low,
  output logic protect_slew_high,
  output logic protect_powerdown
);

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  logic [15:0] pin_function_settings;
  logic [15:0] device_mode_settings;
  logic protect_flag;
  logic [3:0] pin_channel_mask;
  logic [3:0] pin_input_function_code;
  logic pin_input_enable;
  logic input_filter_enable;
  logic [1:0] protect_action;

  assign pin_channel_mask = pin_function_settings[POS_MASK_LO +: NUM_CH];
  assign pin_input_function_code = pin_function_settings[POS_CODE_LO +: 4];
  assign pin_input_enable = pin_function_settings[POS_INPUT_EN];
  assign input_filter_enable = pin_function_settings[POS_FILTER_EN];
  assign protect_action = device_mode_settings[POS_ACTION_LO +: 2];

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------
  logic sync_a, sync_b, sync_c, pin_clean, pin_level, pin_prev;
  logic [3:0] filter_count;

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
      pin_clean <= 1'b1;
    end
    else
    begin
      sync_a <= gpio_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_b == sync_c)
        pin_clean <= sync_c;
    end

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      pin_level <= 1'b1;
      filter_count <= 4'h0;
    end
    else if (!input_filter_enable || pin_clean == pin_level)
    begin
      filter_count <= 4'h0;
      if (!input_filter_enable)
        pin_level <= pin_clean;
    end
    else if (filter_count == FILTER_LAST)
    begin
      pin_level <= pin_clean;
      filter_count <= 4'h0;
    end
    else
      filter_count <= filter_count + 4'h1;

  // edge history
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      pin_prev <= 1'b1;
    else
      pin_prev <= pin_level;

  // nothing acts unless input mode is on
  logic fall, rise, low, high;
  assign fall = pin_input_enable && pin_prev && !pin_level;
  assign rise = pin_input_enable && !pin_prev && pin_level;
  assign low = pin_input_enable && !pin_level;
  assign high = pin_input_enable && pin_level;

  function automatic logic is_fn(input logic [3:0] code, input logic [3:0] fn);
    is_fn = (code == fn);
  endfunction : is_fn

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  logic write_ok, leave_reset;
  // lock rejects writes except the unlock field
  assign write_ok = reg_wr_en && (!map_locked || reg_addr == ADDR_UNLOCK);
  // leaving reset on the rise after the fall
  assign leave_reset = device_reset && pin_input_enable && rise;

  // pin function settings, with reset-code clearing
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      pin_function_settings <= PIN_CFG_RESET;
    else if (leave_reset && !nvm_keeps_reset_cfg)
      pin_function_settings[POS_CODE_LO +: 4] <= FN_NONE;
    else if (write_ok && reg_addr == ADDR_PIN_CFG)
      pin_function_settings <= reg_wdata & PIN_CFG_RW_MASK;

  // mode settings; reserved bits store what software writes
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      device_mode_settings <= MODE_CFG_RESET;
    else if (write_ok && reg_addr == ADDR_MODE_CFG)
      device_mode_settings <= reg_wdata;

  // read data and unlock strobe
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      reg_rdata <= 16'h0000;
      unlock_write <= 1'b0;
    end
    else
    begin
      unlock_write <= write_ok && reg_addr == ADDR_UNLOCK;
      if (reg_rd_en)
        unique case (reg_addr)
          ADDR_PIN_CFG: reg_rdata <= pin_function_settings;
          ADDR_MODE_CFG: reg_rdata <= device_mode_settings;
          ADDR_STATUS: reg_rdata <= 16'(protect_flag) << POS_PROTECT_FLAG;
          default: reg_rdata <= 16'h0000;
        endcase
    end

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      reference_pin_select <= 1'b0;
    else
      reference_pin_select <= device_mode_settings[POS_REF_SEL];

  // ----------------------------------------------------------------
  // global functions
  // ----------------------------------------------------------------
  // global actions ignore the channel mask
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      fault_dump_start <= 1'b0;
      output_clear <= 1'b0;
      device_reset <= 1'b0;
      nvm_write_allowed <= 1'b0;
      map_locked <= 1'b0;
    end
    else
    begin
      fault_dump_start <= fall && is_fn(pin_input_function_code, FN_FAULT_DUMP);
      output_clear <= low && is_fn(pin_input_function_code, FN_CLEAR);
      if (fall && is_fn(pin_input_function_code, FN_RESET))
        device_reset <= 1'b1;
      else if (leave_reset)
        device_reset <= 1'b0;
      // NVM allowed after fall, blocked while high
      if (!is_fn(pin_input_function_code, FN_NVM_PROTECT) || high)
        nvm_write_allowed <= 1'b0;
      else if (fall)
        nvm_write_allowed <= 1'b1;
      map_locked <= high && is_fn(pin_input_function_code, FN_MAP_LOCK);
    end

  // ----------------------------------------------------------------
  // channel functions
  // ----------------------------------------------------------------
  // one mask bit gates each channel
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    logic sel;
    assign sel = pin_channel_mask[ch];
    always_ff @(posedge clk_sys or posedge sys_rst)
      if (sys_rst)
      begin
        current_output_down[ch] <= 1'b0;
        voltage_output_down[ch] <= 1'b0;
        sync_output_load[ch] <= 1'b0;
        wave_stop[ch] <= 1'b0;
        wave_start[ch] <= 1'b0;
        margin_low[ch] <= 1'b0;
        margin_high[ch] <= 1'b0;
      end
      else
      begin
        current_output_down[ch] <= sel && low
          && is_fn(pin_input_function_code, FN_CURRENT_PWR);
        voltage_output_down[ch] <= sel && low
          && is_fn(pin_input_function_code, FN_VOLTAGE_PWR);
        // load needs mask and sync select
        sync_output_load[ch] <= sel && fall && channel_sync_select[ch]
          && is_fn(pin_input_function_code, FN_SYNC_LOAD);
        wave_stop[ch] <= sel && fall
          && is_fn(pin_input_function_code, FN_WAVE);
        wave_start[ch] <= sel && rise
          && is_fn(pin_input_function_code, FN_WAVE);
        margin_low[ch] <= sel && fall
          && is_fn(pin_input_function_code, FN_MARGIN);
        margin_high[ch] <= sel && rise
          && is_fn(pin_input_function_code, FN_MARGIN);
      end
  end : g_ch

  // ----------------------------------------------------------------
  // safe shutdown sequence
  // ----------------------------------------------------------------
  protect_state_e prot_state;
  logic protect_trigger;
  assign protect_trigger = fall && is_fn(pin_input_function_code, FN_PROTECT);

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      prot_state <= prot_idle;
      protect_load_nvm <= 1'b0;
      protect_slew_low <= 1'b0;
      protect_slew_high <= 1'b0;
      protect_powerdown <= 1'b0;
    end
    else
    begin
      protect_load_nvm <= 1'b0;
      protect_powerdown <= 1'b0;
      unique case (prot_state)
        prot_idle:
          if (protect_trigger)
            unique case (protect_action)
              ACT_POWERDOWN: prot_state <= prot_down;
              ACT_NVM_CODE: prot_state <= prot_nvm;
              default:
              begin
                prot_state <= prot_slew;
                protect_slew_low <= protect_action == ACT_MARGIN_LOW;
                protect_slew_high <= protect_action != ACT_MARGIN_LOW;
              end
            endcase
        prot_nvm:
        begin
          protect_load_nvm <= 1'b1;
          prot_state <= prot_down;
        end
        prot_slew:
          if (slew_done)
          begin
            protect_slew_low <= 1'b0;
            protect_slew_high <= 1'b0;
            prot_state <= prot_down;
          end
        prot_down:
        begin
          protect_powerdown <= 1'b1;
          prot_state <= prot_idle;
        end
      endcase
    end

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      protect_flag <= 1'b0;
    else if (prot_state == prot_down)
      protect_flag <= 1'b1;
    else if (reg_rd_en && reg_addr == ADDR_STATUS)
      protect_flag <= 1'b0;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_fall_code(logic [3:0] fn);
    fall && pin_input_function_code == fn;
  endsequence

  property p_fault_dump;
    @(posedge clk_sys) disable iff (sys_rst)
    s_fall_code(FN_FAULT_DUMP) |=> fault_dump_start;
  endproperty
  a_fault_dump: assert property (p_fault_dump)
    else $error("fault dump not started");

  property p_no_enable;
    @(posedge clk_sys) disable iff (sys_rst)
    !pin_input_enable |=> !fault_dump_start && sync_output_load == 4'h0;
  endproperty
  a_no_enable: assert property (p_no_enable)
    else $error("action while input disabled");

  property p_clear_low;
    @(posedge clk_sys) disable iff (sys_rst)
    output_clear |-> $past(!pin_level && pin_input_function_code == FN_CLEAR);
  endproperty
  a_clear_low: assert property (p_clear_low)
    else $error("clear without low pin");

  property p_mask;
    @(posedge clk_sys) disable iff (sys_rst)
    ##1 (wave_stop | margin_low | current_output_down)
      == ((wave_stop | margin_low | current_output_down)
          & $past(pin_channel_mask));
  endproperty
  a_mask: assert property (p_mask)
    else $error("unselected channel acted");

  property p_reset_span;
    @(posedge clk_sys) disable iff (sys_rst)
    s_fall_code(FN_RESET) ##1 !rise |=> device_reset;
  endproperty
  a_reset_span: assert property (p_reset_span)
    else $error("reset not held");

  property p_lock;
    @(posedge clk_sys) disable iff (sys_rst)
    map_locked && reg_wr_en && reg_addr == ADDR_PIN_CFG
      && !(leave_reset && !nvm_keeps_reset_cfg)
      |=> $stable(pin_function_settings);
  endproperty
  a_lock: assert property (p_lock)
    else $error("write passed the lock");

  sequence s_direct_down;
    protect_trigger && protect_action == ACT_POWERDOWN ##2 protect_powerdown;
  endsequence

  property p_protect_direct;
    @(posedge clk_sys) disable iff (sys_rst)
    prot_state == prot_idle && protect_trigger
      && protect_action == ACT_POWERDOWN |-> s_direct_down;
  endproperty
  a_protect_direct: assert property (p_protect_direct)
    else $error("power down step late");

  property p_flag_set;
    @(posedge clk_sys) disable iff (sys_rst)
    protect_powerdown |-> protect_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("done flag missing");

endmodule : gpio_input_function_dispatch

//--- gpio_input_pkg.sv
package gpio_input_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h23;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h24;
  localparam logic [7:0] ADDR_MODE_CFG = 8'h25;
  localparam logic [7:0] ADDR_UNLOCK = 8'hE1;
  localparam logic [15:0] PIN_CFG_RESET = 16'h0000;
  localparam logic [15:0] MODE_CFG_RESET = 16'h0000;
  localparam logic [15:0] PIN_CFG_RW_MASK = 16'hBFFF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_FILTER_EN = 15;
  localparam int POS_MASK_LO = 5;
  localparam int POS_CODE_LO = 1;
  localparam int POS_INPUT_EN = 0;
  localparam int POS_REF_SEL = 13;
  localparam int POS_ACTION_LO = 8;
  localparam int POS_PROTECT_FLAG = 8;
  localparam int NUM_CH = 4;

  // ----------------------------------------------------------------
  // input function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_FAULT_DUMP = 4'h2;
  localparam logic [3:0] FN_CURRENT_PWR = 4'h3;
  localparam logic [3:0] FN_VOLTAGE_PWR = 4'h4;
  localparam logic [3:0] FN_PROTECT = 4'h5;
  localparam logic [3:0] FN_CLEAR = 4'h7;
  localparam logic [3:0] FN_SYNC_LOAD = 4'h8;
  localparam logic [3:0] FN_WAVE = 4'h9;
  localparam logic [3:0] FN_MARGIN = 4'hA;
  localparam logic [3:0] FN_RESET = 4'hB;
  localparam logic [3:0] FN_NVM_PROTECT = 4'hC;
  localparam logic [3:0] FN_MAP_LOCK = 4'hD;
  localparam logic [3:0] FN_NONE = 4'h0;

  // safe shutdown actions
  localparam logic [1:0] ACT_POWERDOWN = 2'h0;
  localparam logic [1:0] ACT_NVM_CODE = 2'h1;
  localparam logic [1:0] ACT_MARGIN_LOW = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_NS = 100;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] FILTER_LAST = 4'(FILTER_CYCLES - 1);

  typedef enum logic [1:0] {
    prot_idle,
    prot_nvm,
    prot_slew,
    prot_down
  } protect_state_e;

endpackage : gpio_input_pkg

//--- pin_driver.sv
// --------------------------------------------------------------
// external controller that drives the pin
// --------------------------------------------------------------
module pin_driver
(
  // clock
  input wire logic clk_sys,
  // pin
  output logic gpio_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // pin idles high so the device sees no false falling edge
  initial gpio_pin = 1'b1;

  // held level
  // levels are held by the caller for longer than the sync and
  // filter delay, so a low then high drive forms a clean pulse
  task automatic drive(input logic v);
    @(negedge clk_sys);
    gpio_pin = v;
  endtask : drive

endmodule : pin_driver

//--- tb_top.sv
// --------------------------------------------------------------
// self-checking bench for the pin input dispatch
// --------------------------------------------------------------
module tb_top
  import gpio_input_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic gpio_pin;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic unlock_write;
  logic [3:0] channel_sync_select = 4'h0;
  logic nvm_keeps_reset_cfg = 1'b0;
  logic slew_done = 1'b0;
  logic fault_dump_start, output_clear, device_reset;
  logic nvm_write_allowed, map_locked, reference_pin_select;
  logic [3:0] current_output_down, voltage_output_down;
  logic [3:0] sync_output_load, wave_stop, wave_start;
  logic [3:0] margin_low, margin_high;
  logic protect_load_nvm, protect_slew_low;
  logic protect_slew_high, protect_powerdown;
  logic [15:0] rd;
  int err_total = 0;
  int checks_done = 0;
  int n;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  pin_driver u_pin (
    .clk_sys(clk_sys),
    .gpio_pin(gpio_pin)
  );

  gpio_input_function_dispatch DUT (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .gpio_pin(gpio_pin),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .unlock_write(unlock_write),
    .channel_sync_select(channel_sync_select),
    .nvm_keeps_reset_cfg(nvm_keeps_reset_cfg),
    .slew_done(slew_done),
    .fault_dump_start(fault_dump_start),
    .output_clear(output_clear),
    .device_reset(device_reset),
    .nvm_write_allowed(nvm_write_allowed),
    .map_locked(map_locked),
    .reference_pin_select(reference_pin_select),
    .current_output_down(current_output_down),
    .voltage_output_down(voltage_output_down),
    .sync_output_load(sync_output_load),
    .wave_stop(wave_stop),
    .wave_start(wave_start),
    .margin_low(margin_low),
    .margin_high(margin_high),
    .protect_load_nvm(protect_load_nvm),
    .protect_slew_low(protect_slew_low),
    .protect_slew_high(protect_slew_high),
    .protect_powerdown(protect_powerdown)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic complete_run();
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // observed outputs by index, single bits zero extended
  function automatic logic [3:0] probe(input int k);
    case (k)
      0: probe = {3'h0, fault_dump_start};
      1: probe = {3'h0, output_clear};
      2: probe = {3'h0, device_reset};
      3: probe = {3'h0, nvm_write_allowed};
      4: probe = {3'h0, map_locked};
      5: probe = {3'h0, reference_pin_select};
      6: probe = current_output_down;
      7: probe = voltage_output_down;
      8: probe = sync_output_load;
      9: probe = wave_stop;
      10: probe = wave_start;
      11: probe = margin_low;
      12: probe = margin_high;
      13: probe = {3'h0, protect_load_nvm};
      14: probe = {3'h0, protect_slew_low};
      15: probe = {3'h0, protect_slew_high};
      16: probe = {3'h0, protect_powerdown};
      default: probe = 4'h0;
    endcase
  endfunction : probe

  // bounded wait for an output value, then compare
  task automatic wait_out(input int k, input logic [3:0] e, output int c);
    c = 0;
    while (probe(k) !== e && c < 60)
    begin
      @(negedge clk_sys);
      c++;
    end
    check({12'h0, probe(k)}, {12'h0, e});
    if (c >= 60)
      complete_run();
  endtask : wait_out

  // an output must stay zero for c cycles
  task automatic expect_none(input int k, input int c);
    logic [3:0] seen;
    seen = 4'h0;
    repeat (c)
    begin
      @(negedge clk_sys);
      seen = seen | probe(k);
    end
    check({12'h0, seen}, 16'h0000);
  endtask : expect_none

  task automatic settle();
    repeat (25) @(negedge clk_sys);
  endtask : settle

  // write strobe held across one rising edge
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask : reg_write

  // read data is registered one cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask : reg_read

  task automatic set_cfg(input logic [3:0] m, input logic [3:0] c,
                         input logic f);
    reg_write(ADDR_PIN_CFG, {f, 6'h00, m, c, 1'b1});
    settle();
  endtask : set_cfg

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    reg_read(ADDR_PIN_CFG, rd);
    check(rd, PIN_CFG_RESET);
    reg_read(ADDR_MODE_CFG, rd);
    check(rd, MODE_CFG_RESET);
    reg_write(ADDR_PIN_CFG, 16'hFFFF);
    reg_read(ADDR_PIN_CFG, rd);
    check(rd, 16'hBFFF);
    reg_write(ADDR_PIN_CFG, 16'h0000);
    reg_read(8'h30, rd);
    check(rd, 16'h0000);
  endtask : t_regs

  task automatic t_enable();
    reg_write(ADDR_PIN_CFG, {11'h000, FN_FAULT_DUMP, 1'b0});
    settle();
    u_pin.drive(1'b0);
    expect_none(0, 30);
    u_pin.drive(1'b1);
    settle();
  endtask : t_enable

  task automatic t_fault();
    for (int f = 0; f < 2; f++)
    begin
      set_cfg(4'h0, FN_FAULT_DUMP, f[0]);
      u_pin.drive(1'b0);
      wait_out(0, 4'h1, n);
      check({15'h0, fault_dump_start}, 16'h0001);
      check({15'h0, f ? n >= 12 : n <= 9}, 16'h0001);
      expect_none(0, 20);
      u_pin.drive(1'b1);
      expect_none(0, 30);
    end
  endtask : t_fault

  // level functions: two channel ones masked, then a global one
  task automatic t_levels();
    logic [3:0] code [3] = '{FN_CURRENT_PWR, FN_VOLTAGE_PWR, FN_CLEAR};
    logic [3:0] msk [3] = '{4'h5, 4'h5, 4'h0};
    logic [3:0] lo [3] = '{4'h5, 4'h5, 4'h1};
    int pr [3] = '{6, 7, 1};
    for (int i = 0; i < 3; i++)
    begin
      set_cfg(msk[i], code[i], 1'b0);
      u_pin.drive(1'b0);
      wait_out(pr[i], lo[i], n);
      check({15'h0, output_clear}, {15'h0, i == 2});
      check({12'h0, current_output_down}, i == 0 ? 16'h0005 : 16'h0000);
      check({12'h0, voltage_output_down}, i == 1 ? 16'h0005 : 16'h0000);
      u_pin.drive(1'b1);
      wait_out(pr[i], 4'h0, n);
      settle();
    end
  endtask : t_levels

  // edge functions on a three-channel mask
  task automatic t_edges();
    logic [3:0] code [3] = '{FN_SYNC_LOAD, FN_WAVE, FN_MARGIN};
    logic [3:0] fe [3] = '{4'h3, 4'h7, 4'h7};
    int pf [3] = '{8, 9, 11};
    int pr [3] = '{0, 10, 12};
    // software sets sync select on channels 0 and 1 only, the mask on channels 0 to 2
    channel_sync_select = 4'h3;
    for (int i = 0; i < 3; i++)
    begin
      set_cfg(4'h7, code[i], 1'b0);
      u_pin.drive(1'b0);
      wait_out(pf[i], fe[i], n);
      check({12'h0, sync_output_load | wave_stop | margin_low},
            {12'h0, fe[i]});
      u_pin.drive(1'b1);
      if (i > 0)
      begin
        wait_out(pr[i], 4'h7, n);
        check({12'h0, wave_start | margin_high}, 16'h0007);
      end
      else
        expect_none(8, 12);
      settle();
    end
  endtask : t_edges

  task automatic t_reset();
    for (int k = 0; k < 2; k++)
    begin
      nvm_keeps_reset_cfg = k[0];
      set_cfg(4'h0, FN_RESET, 1'b0);
      u_pin.drive(1'b0);
      wait_out(2, 4'h1, n);
      check({15'h0, device_reset}, 16'h0001);
      // the low level ends as a pulse
      u_pin.drive(1'b1);
      wait_out(2, 4'h0, n);
      settle();
      reg_read(ADDR_PIN_CFG, rd);
      check({12'h0, rd[4:1]}, {12'h0, k ? FN_RESET : FN_NONE});
    end
  endtask : t_reset

  task automatic t_nvm();
    set_cfg(4'h0, FN_NVM_PROTECT, 1'b0);
    check({15'h0, nvm_write_allowed}, 16'h0000);
    u_pin.drive(1'b0);
    wait_out(3, 4'h1, n);
    u_pin.drive(1'b1);
    wait_out(3, 4'h0, n);
  endtask : t_nvm

  task automatic t_lock();
    set_cfg(4'h0, FN_MAP_LOCK, 1'b0);
    wait_out(4, 4'h1, n);
    check({15'h0, map_locked}, 16'h0001);
    reg_write(ADDR_MODE_CFG, 16'h2000);
    reg_read(ADDR_MODE_CFG, rd);
    check(rd, 16'h0000);
    // the lock also holds the pin settings themselves
    reg_write(ADDR_PIN_CFG, 16'h0000);
    reg_read(ADDR_PIN_CFG, rd);
    check(rd, {11'h000, FN_MAP_LOCK, 1'b1});
    reg_write(ADDR_UNLOCK, 16'h0001);
    check({15'h0, unlock_write}, 16'h0001);
    u_pin.drive(1'b0);
    wait_out(4, 4'h0, n);
    // reserved mode bits are written as zero
    reg_write(ADDR_MODE_CFG, 16'h2000);
    reg_read(ADDR_MODE_CFG, rd);
    check(rd, 16'h2000);
    wait_out(5, 4'h1, n);
    check({15'h0, reference_pin_select}, 16'h0001);
    reg_write(ADDR_MODE_CFG, 16'h0000);
    wait_out(5, 4'h0, n);
    set_cfg(4'h0, FN_NONE, 1'b0);
    u_pin.drive(1'b1);
    settle();
  endtask : t_lock

  // every shutdown action, then the done flag read twice
  task automatic t_shutdown();
    for (int a = 0; a < 4; a++)
    begin
      reg_write(ADDR_MODE_CFG, {6'h00, a[1:0], 8'h00});
      set_cfg(4'h0, FN_PROTECT, 1'b0);
      u_pin.drive(1'b0);
      if (a == 1)
      begin
        wait_out(13, 4'h1, n);
        check({15'h0, protect_load_nvm}, 16'h0001);
      end
      if (a >= 2)
      begin
        wait_out(a == 2 ? 14 : 15, 4'h1, n);
        check({14'h0, protect_slew_high, protect_slew_low},
              a == 2 ? 16'h0001 : 16'h0002);
        slew_done = 1'b1;
      end
      wait_out(16, 4'h1, n);
      check({15'h0, protect_powerdown}, 16'h0001);
      slew_done = 1'b0;
      reg_read(ADDR_STATUS, rd);
      check({15'h0, rd[8]}, 16'h0001);
      reg_read(ADDR_STATUS, rd);
      check({15'h0, rd[8]}, 16'h0000);
      u_pin.drive(1'b1);
      settle();
    end
  endtask : t_shutdown

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_regs();
    t_enable();
    t_fault();
    t_levels();
    t_edges();
    t_reset();
    t_nvm();
    t_lock();
    t_shutdown();
    complete_run();
  end

endmodule : tb_top
